// file: core/bcdadc_cfg.svh
// constants for the bcd converter and its serial host end
`ifndef BCDADC_CFG_SVH
`define BCDADC_CFG_SVH
`define BA_AZ_CYC 10001
`define BA_INT_CYC 10000
`define BA_DE_CYC 20001
`define BA_CYC_LEN 40002
`define BA_DIGIT_PER 8'd200
`define BA_STROBE_AT 8'd100
`define BA_BAUD_DIV 8'd16
`define BA_UNDER_D3 4'h1
`define BA_UNDER_D2 4'h8
`define BA_BLANK_NIB 4'hf
`define BA_REG_CTRL 2'd0
`define BA_REG_STAT 2'd1
`define BA_REG_LAST 2'd2
`define BA_REG_NONE 2'd3
`define BA_OFF_CTRL 8'h00
`define BA_OFF_STAT 8'h04
`define BA_OFF_LAST 8'h08
`define BA_CTRL_RUN 0
`define BA_CTRL_START 1
`define BA_CTRL_HOLD 2
`define BA_STAT_BUSY 0
`define BA_STAT_DRDY 1
`define BA_STAT_OVF 2
`define BA_STAT_EMPTY 3
`define BA_STAT_FULL 4
`define BA_FIFO_W 9
`define BA_FIFO_D 8
`endif

// file: core/bcdadc_pkg.sv
// types for both ends: phase states for the converter, serial states for the host
package bcdadc_pkg;
  typedef enum logic [1:0] {PH_AZ, PH_INT, PH_DE} bcdadc_phase_t;
  typedef enum logic [0:0] {TX_IDLE, TX_SHIFT} bcdadc_tx_t;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} bcdadc_rx_t;
endpackage

// file: core/bcdadc_if.sv
// digit link between converter and host end
`timescale 1ns/1ps
`default_nettype none
interface bcdadc_if;
  logic strobe;
  logic [2:0] digit_idx;
  logic [3:0] bcd;
  logic polarity;
  logic overrange;
  logic underrange;
  logic busy;
  logic run;
  modport dev (output strobe, output digit_idx, output bcd, output polarity,
               output overrange, output underrange, output busy, input run);
  modport host (input strobe, input digit_idx, input bcd, input polarity,
                input overrange, input underrange, input busy, output run);
endinterface
`default_nettype wire

// file: core/bcdadc_dev.sv
// converter end: phase sequencer, bcd counter, digit scan
`timescale 1ns/1ps
`default_nettype none
`include "bcdadc_cfg.svh"
module bcdadc_dev
  import bcdadc_pkg::*;
#(
  parameter int AZ_CYC = `BA_AZ_CYC,
  parameter int INT_CYC = `BA_INT_CYC,
  parameter int DE_CYC = `BA_DE_CYC
) (
  bcdadc_if.dev link,
  input wire logic CLOCK,
  input wire logic RESET_N,
  input wire logic CE,
  input wire logic ZERO_CROSS,
  input wire logic POLARITY_IN,
  output logic DISPLAY_BLANK,
  output logic RESULT_VALID
);
  function automatic logic [19:0] bcd_inc(input logic [19:0] v);
    logic [19:0] r;
    logic c;
    r = v;
    c = 1'b1;
    for (int i = 0; i < 5; i++) begin
      if (c) begin
        if (v[4*i +: 4] == 4'h9) begin
          r[4*i +: 4] = 4'h0;
        end else begin
          r[4*i +: 4] = v[4*i +: 4] + 4'h1;
          c = 1'b0;
        end
      end
    end
    return r;
  endfunction

  bcdadc_phase_t phase_q, phase_d;
  logic [15:0] pcnt_q, pcnt_d;
  logic [19:0] cnt_q, cnt_d, res_q, res_d;
  logic zc1_q, zc2_q, p1_q, p2_q;
  logic pol_q, pol_d, crossed_q, crossed_d, over_q, over_d, under_q, under_d;
  logic blink_q, blink_d, blank_q, blank_d, valid_q, valid_d, busy_q, busy_d;
  logic scan_q, scan_d, strobe_q, strobe_d;
  logic [2:0] idx_q, idx_d, didx_q, didx_d;
  logic [7:0] scnt_q, scnt_d;
  logic [3:0] dig_q, dig_d;
  logic fin_over;

  always_comb begin
    phase_d = phase_q;
    pcnt_d = pcnt_q + 16'h0001;
    cnt_d = cnt_q;
    res_d = res_q;
    pol_d = pol_q;
    crossed_d = crossed_q;
    over_d = over_q;
    under_d = under_q;
    blink_d = blink_q;
    blank_d = blank_q;
    valid_d = 1'b0;
    scan_d = scan_q;
    strobe_d = 1'b0;
    idx_d = idx_q;
    didx_d = didx_q;
    scnt_d = scnt_q;
    dig_d = dig_q;
    fin_over = !crossed_q && !zc2_q;
    unique case (phase_q)
      PH_AZ: begin
        if (pcnt_q == 16'h0000) begin
          cnt_d = '0;
        end
        if (pcnt_q >= 16'(AZ_CYC - 1)) begin
          pcnt_d = pcnt_q;
          if (link.run) begin
            phase_d = PH_INT;
            pcnt_d = '0;
          end
        end
      end
      PH_INT: begin
        if (pcnt_q == 16'(INT_CYC - 1)) begin
          phase_d = PH_DE;
          pcnt_d = '0;
          pol_d = p2_q;
          crossed_d = 1'b0;
        end
      end
      PH_DE: begin
        if (!crossed_q && zc2_q) begin
          crossed_d = 1'b1;
        end else if (!crossed_q && pcnt_q != 16'h0000) begin
          cnt_d = bcd_inc(cnt_q);
        end
        if (pcnt_q == 16'(DE_CYC - 1)) begin
          phase_d = PH_AZ;
          pcnt_d = '0;
          over_d = fin_over;
          blink_d = fin_over && !blink_q;
          blank_d = fin_over && blink_q;
          if (fin_over) begin
            res_d = blink_q ? {5{`BA_BLANK_NIB}} : 20'h00000;
          end else begin
            res_d = cnt_d;
          end
          under_d = !fin_over && cnt_d[19:16] == 4'h0 && (cnt_d[15:12] == 4'h0 ||
                    (cnt_d[15:12] == `BA_UNDER_D3 && cnt_d[11:8] < `BA_UNDER_D2));
          valid_d = 1'b1;
          scan_d = 1'b1;
          idx_d = '0;
          scnt_d = '0;
        end
      end
    endcase
    busy_d = phase_d != PH_AZ;
    if (scan_q) begin
      scnt_d = scnt_q + 8'h01;
      if (scnt_q == `BA_STROBE_AT) begin
        strobe_d = 1'b1;
        didx_d = idx_q;
        dig_d = res_q[4*(3'd4 - idx_q) +: 4];
      end
      if (scnt_q == `BA_DIGIT_PER - 8'h01) begin
        scnt_d = '0;
        idx_d = idx_q + 3'd1;
        if (idx_q == 3'd4) begin
          scan_d = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      phase_q <= PH_AZ;
      pcnt_q <= '0;
      cnt_q <= '0;
      res_q <= '0;
      {zc1_q, zc2_q, p1_q, p2_q} <= 4'h0;
      {pol_q, crossed_q, over_q, under_q} <= 4'h0;
      {blink_q, blank_q, valid_q, busy_q} <= 4'h0;
      {scan_q, strobe_q} <= 2'b00;
      idx_q <= '0;
      didx_q <= '0;
      scnt_q <= '0;
      dig_q <= '0;
    end else if (CE) begin
      phase_q <= phase_d;
      pcnt_q <= pcnt_d;
      cnt_q <= cnt_d;
      res_q <= res_d;
      zc1_q <= ZERO_CROSS;
      zc2_q <= zc1_q;
      p1_q <= POLARITY_IN;
      p2_q <= p1_q;
      {pol_q, crossed_q, over_q, under_q} <= {pol_d, crossed_d, over_d, under_d};
      {blink_q, blank_q, valid_q, busy_q} <= {blink_d, blank_d, valid_d, busy_d};
      {scan_q, strobe_q} <= {scan_d, strobe_d};
      idx_q <= idx_d;
      didx_q <= didx_d;
      scnt_q <= scnt_d;
      dig_q <= dig_d;
    end
  end

  assign link.strobe = strobe_q;
  assign link.digit_idx = didx_q;
  assign link.bcd = dig_q;
  assign link.polarity = pol_q;
  assign link.overrange = over_q;
  assign link.underrange = under_q;
  assign link.busy = busy_q;
  assign DISPLAY_BLANK = blank_q;
  assign RESULT_VALID = valid_q;
endmodule // bcdadc_dev
`default_nettype wire

// file: core/bcdadc_host.sv
// host end: word builder, fifo, serial transmitter and receiver, apb registers
`timescale 1ns/1ps
`default_nettype none
`include "bcdadc_cfg.svh"
module bcdadc_fifo #(
  parameter int W = `BA_FIFO_W,
  parameter int D = `BA_FIFO_D
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW:0] wp_q, wp_d, rp_q, rp_d;
  logic full, empty, push, pop;

  always_comb begin
    empty = wp_q == rp_q;
    full = wp_q[AW-1:0] == rp_q[AW-1:0] && wp_q[AW] != rp_q[AW];
    push = ce && in_valid && !full;
    pop = ce && out_ready && !empty;
    wp_d = push ? wp_q + 1'b1 : wp_q;
    rp_d = pop ? rp_q + 1'b1 : rp_q;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_q <= '0;
      rp_q <= '0;
    end else begin
      wp_q <= wp_d;
      rp_q <= rp_d;
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp_q[AW-1:0]] <= in_data;
    end
  end

  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = mem[rp_q[AW-1:0]];
endmodule // bcdadc_fifo

module bcdadc_host
  import bcdadc_pkg::*;
(
  bcdadc_if.host link,
  input wire logic CLOCK,
  input wire logic RESET_N,
  input wire logic CE,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic PREADY,
  output logic [31:0] PRDATA,
  output logic PSLVERR,
  input wire logic RECEIVER_SERIAL_INPUT,
  output logic TX_SERIAL_OUT,
  output logic EVEN_PARITY_SELECT,
  output logic DATA_READY
);
  function automatic logic [1:0] reg_sel(input logic [7:0] a);
    unique case (a)
      `BA_OFF_CTRL: reg_sel = `BA_REG_CTRL;
      `BA_OFF_STAT: reg_sel = `BA_REG_STAT;
      `BA_OFF_LAST: reg_sel = `BA_REG_LAST;
      default: reg_sel = `BA_REG_NONE;
    endcase
  endfunction

  logic rxs1_q, rxs2_q;
  logic run_q, run_d, ctl_run_q, ctl_run_d, hold_q, hold_d, pend_q, pend_d;
  logic busy_p_q, drdy_q, drdy_d, ovf_q, ovf_d;
  logic [7:0] last_q, last_d, rxw_q, rxw_d;
  bcdadc_rx_t rx_st_q, rx_st_d;
  logic [7:0] rx_cnt_q, rx_cnt_d, rx_sh_q, rx_sh_d;
  logic [2:0] rx_bit_q, rx_bit_d;
  bcdadc_tx_t tx_st_q, tx_st_d;
  logic [7:0] tx_cnt_q, tx_cnt_d;
  logic [3:0] tx_bit_q, tx_bit_d;
  logic [10:0] tx_sh_q, tx_sh_d;
  logic tx_q, tx_d, epe_q, epe_d;
  logic rdy_q, rdy_d, err_q, err_d;
  logic [31:0] rd_q, rd_d;
  logic [3:0] id_nib, dat_nib;
  logic [7:0] word;
  logic f_in_ready, f_out_valid, f_pop;
  logic [8:0] f_out;
  logic access, wr_fire, busy_rise, rx_done;

  always_comb begin
    unique case (link.digit_idx)
      3'd0: id_nib = 4'b0000;
      3'd1: id_nib = 4'b1000;
      3'd2: id_nib = 4'b0100;
      3'd3: id_nib = 4'b0010;
      default: id_nib = 4'b0001;
    endcase
    if (link.digit_idx == 3'd0) begin
      dat_nib = {link.polarity, link.overrange, link.underrange, link.bcd[0]};
    end else begin
      dat_nib = link.bcd;
    end
    word = {id_nib, dat_nib};
  end

  bcdadc_fifo #(.W(`BA_FIFO_W), .D(`BA_FIFO_D)) u_fifo (
    .clk(CLOCK),
    .rst_n(RESET_N),
    .ce(CE),
    .in_valid(link.strobe),
    .in_ready(f_in_ready),
    .in_data({link.polarity, word}),
    .out_valid(f_out_valid),
    .out_ready(f_pop),
    .out_data(f_out)
  );

  assign f_pop = tx_st_q == TX_IDLE;

  always_comb begin
    tx_st_d = tx_st_q;
    tx_cnt_d = tx_cnt_q;
    tx_bit_d = tx_bit_q;
    tx_sh_d = tx_sh_q;
    tx_d = tx_q;
    epe_d = epe_q;
    unique case (tx_st_q)
      TX_IDLE: begin
        tx_d = 1'b1;
        if (f_out_valid) begin
          epe_d = f_out[8];
          tx_sh_d = {1'b1, f_out[8] ? ^f_out[7:0] : ~^f_out[7:0], f_out[7:0], 1'b0};
          tx_d = 1'b0;
          tx_cnt_d = '0;
          tx_bit_d = '0;
          tx_st_d = TX_SHIFT;
        end
      end
      TX_SHIFT: begin
        tx_cnt_d = tx_cnt_q + 8'h01;
        if (tx_cnt_q == `BA_BAUD_DIV - 8'h01) begin
          tx_cnt_d = '0;
          tx_sh_d = {1'b1, tx_sh_q[10:1]};
          tx_d = tx_sh_q[1];
          tx_bit_d = tx_bit_q + 4'h1;
          if (tx_bit_q == 4'd10) begin
            tx_st_d = TX_IDLE;
            tx_d = 1'b1;
          end
        end
      end
    endcase
  end

  always_comb begin
    rx_st_d = rx_st_q;
    rx_cnt_d = rx_cnt_q + 8'h01;
    rx_bit_d = rx_bit_q;
    rx_sh_d = rx_sh_q;
    rx_done = 1'b0;
    unique case (rx_st_q)
      RX_IDLE: begin
        rx_cnt_d = '0;
        if (!rxs2_q) begin
          rx_st_d = RX_START;
        end
      end
      RX_START: begin
        if (rx_cnt_q == (`BA_BAUD_DIV >> 1) - 8'h01) begin
          rx_cnt_d = '0;
          rx_bit_d = '0;
          rx_st_d = rxs2_q ? RX_IDLE : RX_DATA;
        end
      end
      RX_DATA: begin
        if (rx_cnt_q == `BA_BAUD_DIV - 8'h01) begin
          rx_cnt_d = '0;
          rx_sh_d = {rxs2_q, rx_sh_q[7:1]};
          rx_bit_d = rx_bit_q + 3'd1;
          if (rx_bit_q == 3'd7) begin
            rx_st_d = RX_STOP;
          end
        end
      end
      RX_STOP: begin
        if (rx_cnt_q == `BA_BAUD_DIV - 8'h01) begin
          rx_st_d = RX_IDLE;
          rx_done = rxs2_q;
        end
      end
    endcase
  end

  always_comb begin
    access = PSEL && PENABLE;
    wr_fire = access && rdy_q && PWRITE;
    busy_rise = link.busy && !busy_p_q;
    rdy_d = access && !rdy_q;
    err_d = access && !rdy_q && reg_sel(PADDR) == `BA_REG_NONE;
    rd_d = '0;
    if (access && !rdy_q && !PWRITE) begin
      unique case (reg_sel(PADDR))
        `BA_REG_CTRL: rd_d = {29'h0, hold_q, 1'b0, ctl_run_q};
        `BA_REG_STAT: rd_d = {16'h0, rxw_q, 3'h0, !f_in_ready, !f_out_valid,
                              ovf_q, drdy_q, link.busy};
        `BA_REG_LAST: rd_d = {24'h0, last_q};
        default: rd_d = '0;
      endcase
    end
    ctl_run_d = ctl_run_q;
    hold_d = hold_q;
    pend_d = pend_q;
    ovf_d = ovf_q;
    if (wr_fire && reg_sel(PADDR) == `BA_REG_CTRL) begin
      ctl_run_d = PWDATA[`BA_CTRL_RUN];
      hold_d = PWDATA[`BA_CTRL_HOLD];
    end
    if (wr_fire && reg_sel(PADDR) == `BA_REG_STAT && PWDATA[`BA_STAT_OVF]) begin
      ovf_d = 1'b0;
    end
    if (link.strobe && !f_in_ready) begin
      ovf_d = 1'b1;
    end
    if (link.busy) begin
      pend_d = 1'b0;
    end
    if (rx_done || (wr_fire && reg_sel(PADDR) == `BA_REG_CTRL && PWDATA[`BA_CTRL_START])) begin
      pend_d = 1'b1;
    end
    run_d = !hold_d && (ctl_run_d || pend_d);
    drdy_d = drdy_q && !busy_rise;
    rxw_d = rxw_q;
    if (rx_done) begin
      drdy_d = 1'b1;
      rxw_d = rx_sh_q;
    end
    last_d = (link.strobe && f_in_ready) ? word : last_q;
  end

  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      {rxs1_q, rxs2_q} <= 2'b11;
      {run_q, ctl_run_q, hold_q, pend_q} <= 4'h0;
      {busy_p_q, drdy_q, ovf_q} <= 3'h0;
      last_q <= '0;
      rxw_q <= '0;
      rx_st_q <= RX_IDLE;
      rx_cnt_q <= '0;
      rx_sh_q <= '0;
      rx_bit_q <= '0;
      tx_st_q <= TX_IDLE;
      tx_cnt_q <= '0;
      tx_bit_q <= '0;
      tx_sh_q <= '1;
      {tx_q, epe_q} <= 2'b10;
      {rdy_q, err_q} <= 2'b00;
      rd_q <= '0;
    end else if (CE) begin
      rxs1_q <= RECEIVER_SERIAL_INPUT;
      rxs2_q <= rxs1_q;
      {run_q, ctl_run_q, hold_q, pend_q} <= {run_d, ctl_run_d, hold_d, pend_d};
      {busy_p_q, drdy_q, ovf_q} <= {link.busy, drdy_d, ovf_d};
      last_q <= last_d;
      rxw_q <= rxw_d;
      rx_st_q <= rx_st_d;
      rx_cnt_q <= rx_cnt_d;
      rx_sh_q <= rx_sh_d;
      rx_bit_q <= rx_bit_d;
      tx_st_q <= tx_st_d;
      tx_cnt_q <= tx_cnt_d;
      tx_bit_q <= tx_bit_d;
      tx_sh_q <= tx_sh_d;
      {tx_q, epe_q} <= {tx_d, epe_d};
      {rdy_q, err_q} <= {rdy_d, err_d};
      rd_q <= rd_d;
    end
  end

  assign link.run = run_q;
  assign PREADY = rdy_q;
  assign PRDATA = rd_q;
  assign PSLVERR = err_q;
  assign TX_SERIAL_OUT = tx_q;
  assign EVEN_PARITY_SELECT = epe_q;
  assign DATA_READY = drdy_q;
endmodule // bcdadc_host
`default_nettype wire

// file: dv/bcdadc_assertions.sv
// concurrent checks on the digit link between the two ends
`timescale 1ns/1ps
`default_nettype none
module bcdadc_assertions #(
  parameter int AZ_CYC = 1000,
  parameter int INT_CYC = 16,
  parameter int DE_CYC = 40
) (
  input wire logic CLOCK,
  input wire logic RESET_N,
  input wire logic strobe,
  input wire logic [2:0] digit_idx,
  input wire logic [3:0] bcd,
  input wire logic polarity,
  input wire logic overrange,
  input wire logic underrange,
  input wire logic busy,
  input wire logic run
);
  logic [2:0] idx_q, idx_d;
  logic [15:0] blen_q, blen_d, per_q, per_d;
  logic held_q, held_d, seen_q, seen_d, rise;
  always_comb begin
    rise = busy && (blen_q == 16'h0);
    idx_d = strobe ? digit_idx : idx_q;
    blen_d = busy ? blen_q + 16'h1 : 16'h0;
    per_d = rise ? 16'h1 : per_q + 16'h1;
    held_d = rise ? 1'b0 : (held_q | !run);
    seen_d = seen_q | rise;
  end
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      idx_q <= 3'h0;
      blen_q <= 16'h0;
      per_q <= 16'h0;
      held_q <= 1'b0;
      seen_q <= 1'b0;
    end else begin
      idx_q <= idx_d;
      blen_q <= blen_d;
      per_q <= per_d;
      held_q <= held_d;
      seen_q <= seen_d;
    end
  end
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RESET_N);
  a_strobe_one_cycle: assert property (strobe |=> !strobe)
    else $error("strobe wider than one cycle");
  a_idx_in_range: assert property (strobe |-> digit_idx <= 3'd4)
    else $error("digit index out of range");
  a_idx_next_digit: assert property (strobe && digit_idx < 3'd4 |-> ##200 (strobe && digit_idx == idx_q + 3'd1))
    else $error("next digit strobe missing or misplaced");
  a_digit_hold: assert property (!strobe |-> $stable(bcd) && $stable(digit_idx))
    else $error("digit changed without strobe");
  a_busy_length: assert property ($fell(busy) |-> blen_q == INT_CYC + DE_CYC)
    else $error("busy length wrong");
  a_cycle_length: assert property (rise && seen_q && !held_q |-> per_q == AZ_CYC + INT_CYC + DE_CYC)
    else $error("conversion cycle length wrong");
  a_autozero_min: assert property ($fell(busy) |=> (!busy) [*8])
    else $error("auto-zero too short");
  a_hold_blocks: assert property ((!run) [*3] |-> !$rose(busy))
    else $error("measurement started while held");
  a_over_not_under: assert property (overrange |-> !underrange)
    else $error("overrange and underrange together");
  c_last_digit: cover property (strobe && digit_idx == 3'd4);
  c_busy_end: cover property ($fell(busy));
  c_over: cover property (strobe && overrange);
  c_under: cover property (strobe && underrange && polarity);
endmodule // bcdadc_assertions
`default_nettype wire

// file: dv/tb.sv
// self-checking bench for both converter ends
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam int AZ = 1000;
  localparam int IN = 16;
  localparam int DE = 40;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic zc = 1'b1;
  logic pol_in = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic rx_in = 1'b1;
  logic pready, pslverr, tx_out, eps, drdy;
  logic [31:0] prdata;
  int n_fail = 0;
  int cmp_count = 0;
  logic [9:0] rxq[$];
  logic blank, rv;
  int n_res = 0;
  bcdadc_if lnk ();
  always #12.5 clk = ~clk;
  bcdadc_dev #(.AZ_CYC(AZ), .INT_CYC(IN), .DE_CYC(DE)) bcdadc_dev_i (.link(lnk.dev), .CLOCK(clk),
    .RESET_N(rst_n), .CE(1'b1), .ZERO_CROSS(zc), .POLARITY_IN(pol_in), .DISPLAY_BLANK(blank), .RESULT_VALID(rv));
  bcdadc_host bcdadc_host_i (.link(lnk.host), .CLOCK(clk), .RESET_N(rst_n), .CE(1'b1), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PREADY(pready), .PRDATA(prdata),
    .PSLVERR(pslverr), .RECEIVER_SERIAL_INPUT(rx_in), .TX_SERIAL_OUT(tx_out), .EVEN_PARITY_SELECT(eps),
    .DATA_READY(drdy));
  bcdadc_assertions #(.AZ_CYC(AZ), .INT_CYC(IN), .DE_CYC(DE)) bcdadc_assertions_i (.CLOCK(clk),
    .RESET_N(rst_n), .strobe(lnk.strobe), .digit_idx(lnk.digit_idx), .bcd(lnk.bcd), .polarity(lnk.polarity),
    .overrange(lnk.overrange), .underrange(lnk.underrange), .busy(lnk.busy), .run(lnk.run));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd,
                     output logic er);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    er = pslverr;
    if (n >= 50) check(32'h0, 32'h1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic get_word(input logic [7:0] exp, input logic pol);
    int n;
    logic [9:0] w;
    n = 0;
    while (rxq.size() == 0 && n < 3000) begin
      @(posedge clk);
      n++;
    end
    check(32'(rxq.size() != 0), 32'h1);
    if (rxq.size() != 0) begin
      w = rxq.pop_front();
      check({24'h0, w[7:0]}, {24'h0, exp});
      check({31'h0, w[8]}, {31'h0, pol ? ^exp : ~^exp});
      check({31'h0, w[9]}, {31'h0, pol});
    end
  endtask
  task automatic burst(input logic pol, input logic [3:0] top, input logic [3:0] dig);
    get_word({4'h0, top}, pol);
    for (int i = 0; i < 4; i++) begin
      get_word({4'(4'h8 >> i), dig}, pol);
    end
  endtask
  task automatic ser_send(input logic [7:0] d);
    logic [9:0] f;
    f = {1'b1, d, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rx_in <= f[i];
      repeat (16) @(posedge clk);
    end
  endtask
  initial begin : tx_mon
    logic [9:0] b;
    forever begin
      @(posedge clk);
      if (tx_out === 1'b0 && rst_n) begin
        repeat (8) @(posedge clk);
        check({31'h0, tx_out}, 32'h0);
        for (int i = 0; i < 10; i++) begin
          repeat (16) @(posedge clk);
          b[i] = tx_out;
        end
        check({31'h0, b[9]}, 32'h1);
        rxq.push_back({eps, b[8:0]});
      end
    end
  end
  always @(posedge clk) begin
    if (rv === 1'b1) begin
      n_res++;
      check({31'h0, blank}, {31'h0, n_res >= 5 && n_res % 2 == 1});
    end
  end
  initial begin : watchdog
    repeat (40000) @(posedge clk);
    n_fail++;
    $display("FAIL %0t watchdog expired", $time);
    test_done();
  end
  initial begin : main
    logic [31:0] rd;
    logic er;
    int n;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    apb(1'b0, 8'h04, 32'h0, rd, er);
    check(rd, 32'h8);
    apb(1'b0, 8'h00, 32'h0, rd, er);
    check(rd, 32'h0);
    apb(1'b1, 8'h0c, 32'hffff_ffff, rd, er);
    check({31'h0, er}, 32'h1);
    apb(1'b0, 8'h0c, 32'h0, rd, er);
    check(rd, 32'h0);
    apb(1'b1, 8'h00, 32'h2, rd, er);
    burst(1'b1, 4'ha, 4'h0);
    apb(1'b0, 8'h08, 32'h0, rd, er);
    check(rd, 32'h10);
    pol_in <= 1'b0;
    n = 0;
    fork
      ser_send(8'h5a);
      while (drdy !== 1'b1 && n < 400) begin
        @(posedge clk);
        n++;
      end
    join
    check(32'(n < 400), 32'h1);
    n = 0;
    while (drdy !== 1'b0 && n < 1100) begin
      @(posedge clk);
      n++;
    end
    check(32'(n < 1100), 32'h1);
    apb(1'b0, 8'h04, 32'h0, rd, er);
    check({24'h0, rd[15:8]}, 32'h5a);
    burst(1'b0, 4'h2, 4'h0);
    apb(1'b1, 8'h00, 32'h5, rd, er);
    repeat (1200) @(posedge clk);
    check({31'h0, lnk.busy}, 32'h0);
    check(32'(rxq.size()), 32'h0);
    zc <= 1'b0;
    apb(1'b1, 8'h00, 32'h2, rd, er);
    while (lnk.busy !== 1'b1) @(posedge clk);
    repeat (26) @(posedge clk);
    zc <= 1'b1;
    get_word(8'h02, 1'b0);
    get_word(8'h80, 1'b0);
    get_word(8'h40, 1'b0);
    get_word(8'h21, 1'b0);
    get_word(8'h12, 1'b0);
    zc <= 1'b0;
    pol_in <= 1'b1;
    apb(1'b1, 8'h00, 32'h1, rd, er);
    burst(1'b1, 4'hc, 4'h0);
    burst(1'b1, 4'hd, 4'hf);
    apb(1'b1, 8'h00, 32'h0, rd, er);
    check(32'(n_res), 32'd6);
    test_done();
  end
endmodule // tb
`default_nettype wire
